/* logic/hpo_pkg.sv */
// Package for the host-side pin output stage: constants, types and encodings
package hpo_pkg;

    // ****************************************
    // Status mux select encodings
    // ****************************************
    localparam logic [1:0] HPO_SEL_OPERATE   = 2'h0;
    localparam logic [1:0] HPO_SEL_BUS_POWER = 2'h1;
    localparam logic [1:0] HPO_SEL_BUS_ACT   = 2'h2;
    localparam logic [1:0] HPO_SEL_SOF       = 2'h3;
    localparam logic [1:0] HPO_SEL_RESET     = HPO_SEL_OPERATE;

    // ****************************************
    // Reset values and the last bit count
    // ****************************************
    localparam logic       HPO_SYNC_RESET    = 1'h0;
    localparam logic       HPO_SS_RESET      = 1'h1;
    localparam logic [7:0] HPO_SHIFT_RESET   = 8'h00;
    localparam logic [2:0] HPO_BIT_CNT_RESET = 3'h0;
    localparam logic [2:0] HPO_BIT_CNT_LAST  = 3'h7;
    localparam logic       HPO_OUT_RESET     = 1'h0;
    localparam logic       HPO_OE_N_RESET    = 1'h1;

    // Internal status signals feeding the mux
    typedef struct packed {
        logic operate;
        logic bus_power_detected;
        logic bus_activity;
        logic sof;
    } hpo_status_t;

    // Interrupt configuration
    typedef struct packed {
        logic irq_enable;
        logic level_mode;
        logic edge_active_high;
    } hpo_irq_cfg_t;

    // Value and active-low enable of a driven pin
    typedef struct packed {
        logic o;
        logic oe_n;
    } hpo_pin_drv_t;

endpackage : hpo_pkg

/* logic/hpo_sync2.sv */
// Two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps

module hpo_sync2 #(
    parameter int        WIDTH = 3,
    parameter bit [31:0] RST   = 32'h0000_0000
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
        if (!i_rst_n) begin
            meta_d = RST[WIDTH-1:0];
            sync_d = RST[WIDTH-1:0];
        end
    end

    always_ff @(posedge i_clock) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign o_sync = sync_q;

endmodule : hpo_sync2

/* logic/hpo_top.sv */
// Host-side pin output stage: serial data pins, status mux and interrupt pin
`timescale 1ns/1ps

// Operation
// - Drive data-out only when selected, full-duplex
// - Data-in pin optionally carries both directions
// - Two-bit field selects muxed status output
// - Select 00 operate,01 power,10 activity,11 frame
// - Edge mode: push-pull, software-selected polarity
// - Level mode: open-drain, low while pending
// - Interrupt pin signals only when enabled
// - Sample on rising, shift on falling clock
// - Slave select high ignores clock; bit count clears
module hpo_top
    import hpo_pkg::*;
(
    input  wire logic         i_clock,
    input  wire logic         i_rst_n,
    input  wire logic         i_sclk,
    input  wire logic         i_ss_n,
    input  wire logic         i_mosi,
    input  wire logic         i_half_duplex,
    input  wire logic         i_tx_load,
    input  wire logic [7:0]   i_tx_byte,
    input  wire logic [1:0]   i_status_sel,
    input  wire hpo_status_t  i_status,
    input  wire hpo_irq_cfg_t i_irq_cfg,
    input  wire logic         i_irq_pending,
    output logic              o_miso,
    output logic              o_miso_oe_n,
    output logic              o_mosi,
    output logic              o_mosi_oe_n,
    output logic [7:0]        o_rx_byte,
    output logic              o_rx_valid,
    output logic              o_muxed_status_out,
    output logic              o_irq,
    output logic              o_irq_oe_n
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] pins_s;
    logic       sclk_s;
    logic       ss_n_s;
    logic       mosi_s;

    hpo_sync2 #(
        .WIDTH (3),
        .RST   (32'({HPO_SYNC_RESET, HPO_SS_RESET, HPO_SYNC_RESET}))
    ) u_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async ({i_sclk, i_ss_n, i_mosi}),
        .o_sync  (pins_s)
    );

    assign sclk_s = pins_s[2];
    assign ss_n_s = pins_s[1];
    assign mosi_s = pins_s[0];

    // ****************************************
    // Status mux decode
    // ****************************************
    function automatic logic mux_status(input logic [1:0] sel, input hpo_status_t st);
        case (sel)
            HPO_SEL_OPERATE:   mux_status = st.operate;
            HPO_SEL_BUS_POWER: mux_status = st.bus_power_detected;
            HPO_SEL_BUS_ACT:   mux_status = st.bus_activity;
            HPO_SEL_SOF:       mux_status = st.sof;
            default:           mux_status = st.operate;
        endcase
    endfunction : mux_status

    // ****************************************
    // Serial shifter state
    // ****************************************
    logic       sclk_prev_q, sclk_prev_d;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic [7:0] tx_sh_q, tx_sh_d;
    logic [2:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] rx_byte_q, rx_byte_d;
    logic       rx_valid_q, rx_valid_d;
    logic       sdo_q, sdo_d;
    logic       miso_oe_n_q, miso_oe_n_d;
    logic       mosi_oe_n_q, mosi_oe_n_d;
    logic       rise;
    logic       fall;

    always_comb begin
        rise        = sclk_s & ~sclk_prev_q;
        fall        = ~sclk_s & sclk_prev_q;
        sclk_prev_d = sclk_s;
        rx_sh_d     = rx_sh_q;
        tx_sh_d     = tx_sh_q;
        bit_cnt_d   = bit_cnt_q;
        rx_byte_d   = rx_byte_q;
        rx_valid_d  = 1'h0;
        sdo_d       = sdo_q;
        if (ss_n_s) begin
            // Deselected: clock edges ignored, bit count cleared
            bit_cnt_d = HPO_BIT_CNT_RESET;
            if (i_tx_load) begin
                tx_sh_d = i_tx_byte;
            end
            sdo_d = tx_sh_d[7];
        end else begin
            if (rise) begin
                rx_sh_d   = {rx_sh_q[6:0], mosi_s};
                bit_cnt_d = bit_cnt_q + 3'h1;
                if (bit_cnt_q == HPO_BIT_CNT_LAST) begin
                    rx_byte_d  = {rx_sh_q[6:0], mosi_s};
                    rx_valid_d = 1'h1;
                end
            end
            if (fall) begin
                // New byte is loaded at the byte boundary
                if (bit_cnt_q == HPO_BIT_CNT_RESET && i_tx_load) begin
                    tx_sh_d = i_tx_byte;
                end else begin
                    tx_sh_d = {tx_sh_q[6:0], 1'h0};
                end
                sdo_d = tx_sh_d[7];
            end
        end
        if (!i_rst_n) begin
            sclk_prev_d = HPO_SYNC_RESET;
            rx_sh_d     = HPO_SHIFT_RESET;
            tx_sh_d     = HPO_SHIFT_RESET;
            bit_cnt_d   = HPO_BIT_CNT_RESET;
            rx_byte_d   = HPO_SHIFT_RESET;
            rx_valid_d  = HPO_OUT_RESET;
            sdo_d       = HPO_OUT_RESET;
        end
    end

    always_ff @(posedge i_clock) begin
        sclk_prev_q <= sclk_prev_d;
        rx_sh_q     <= rx_sh_d;
        tx_sh_q     <= tx_sh_d;
        bit_cnt_q   <= bit_cnt_d;
        rx_byte_q   <= rx_byte_d;
        rx_valid_q  <= rx_valid_d;
        sdo_q       <= sdo_d;
    end

    // ****************************************
    // Data pin enables
    // ****************************************
    // Enables follow the synchronised select, so they lag the pin by three
    // clocks; the master's setup time before its first edge covers that lag
    always_comb begin
        miso_oe_n_d = HPO_OE_N_RESET;
        mosi_oe_n_d = HPO_OE_N_RESET;
        if (!ss_n_s) begin
            // Full duplex drives data-out; half duplex turns data-in around
            miso_oe_n_d = i_half_duplex;
            mosi_oe_n_d = ~i_half_duplex;
        end
        if (!i_rst_n) begin
            miso_oe_n_d = HPO_OE_N_RESET;
            mosi_oe_n_d = HPO_OE_N_RESET;
        end
    end

    always_ff @(posedge i_clock) begin
        miso_oe_n_q <= miso_oe_n_d;
        mosi_oe_n_q <= mosi_oe_n_d;
    end

    // ****************************************
    // Status mux
    // ****************************************
    logic muxed_status_out_q, muxed_status_out_d;

    always_comb begin
        muxed_status_out_d = mux_status(i_status_sel, i_status);
        if (!i_rst_n) begin
            muxed_status_out_d = HPO_OUT_RESET;
        end
    end

    always_ff @(posedge i_clock) begin
        muxed_status_out_q <= muxed_status_out_d;
    end

    // ****************************************
    // Interrupt pin
    // ****************************************
    hpo_pin_drv_t irq_drv_q, irq_drv_d;
    logic         irq_active;

    always_comb begin
        irq_active = i_irq_pending & i_irq_cfg.irq_enable;
        if (i_irq_cfg.level_mode) begin
            // Open drain: only ever pull low, otherwise release
            irq_drv_d.o    = 1'h0;
            irq_drv_d.oe_n = ~irq_active;
        end else begin
            // Selected polarity while active, the inverse level otherwise
            irq_drv_d.o    = irq_active ~^ i_irq_cfg.edge_active_high;
            irq_drv_d.oe_n = 1'h0;
        end
        if (!i_rst_n) begin
            irq_drv_d.o    = HPO_OUT_RESET;
            irq_drv_d.oe_n = HPO_OE_N_RESET;
        end
    end

    always_ff @(posedge i_clock) begin
        irq_drv_q <= irq_drv_d;
    end

    assign o_miso             = sdo_q;
    assign o_miso_oe_n        = miso_oe_n_q;
    assign o_mosi             = sdo_q;
    assign o_mosi_oe_n        = mosi_oe_n_q;
    assign o_rx_byte          = rx_byte_q;
    assign o_rx_valid         = rx_valid_q;
    assign o_muxed_status_out = muxed_status_out_q;
    assign o_irq              = irq_drv_q.o;
    assign o_irq_oe_n         = irq_drv_q.oe_n;

endmodule : hpo_top

/* verification/hpo_properties.sv */
// Checker for the pin output stage ports
`timescale 1ns/1ps
module hpo_props
    import hpo_pkg::*;
(
    input wire logic         i_clock,
    input wire logic         i_rst_n,
    input wire logic         i_ss_n,
    input wire logic         i_half_duplex,
    input wire logic [1:0]   i_status_sel,
    input wire hpo_status_t  i_status,
    input wire hpo_irq_cfg_t i_irq_cfg,
    input wire logic         i_irq_pending,
    input wire logic         o_miso_oe_n,
    input wire logic         o_mosi_oe_n,
    input wire logic         o_rx_valid,
    input wire logic         o_muxed_status_out,
    input wire logic         o_irq,
    input wire logic         o_irq_oe_n
);
    // ****************
    // Helpers
    // ****************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    wire logic act  = i_irq_cfg.irq_enable & i_irq_pending;
    wire logic lvl  = i_irq_cfg.edge_active_high ^ !act;
    wire logic pick = i_status[2'h3 - i_status_sel];
    // Pin edges pass two sync flops and a register, so four samples suffice
    property p_ss; i_ss_n [*4] |-> o_miso_oe_n; endproperty
    a_ss: assert property (p_ss) else $error("miso driven");
    property p_sel; (!i_ss_n && !i_half_duplex) [*4] |-> !o_miso_oe_n; endproperty
    a_sel: assert property (p_sel) else $error("miso released");
    property p_hd; i_half_duplex |=> o_miso_oe_n; endproperty
    a_hd: assert property (p_hd) else $error("miso driven in half duplex");
    property p_mosi; !i_half_duplex |=> o_mosi_oe_n; endproperty
    a_mosi: assert property (p_mosi) else $error("mosi driven in full duplex");
    property p_mux; 1 |=> o_muxed_status_out == $past(pick); endproperty
    a_mux: assert property (p_mux) else $error("mux");
    property p_sof; i_status_sel == HPO_SEL_SOF |=> o_muxed_status_out == $past(i_status.sof); endproperty
    a_sof: assert property (p_sof) else $error("sof");
    property p_edge; !i_irq_cfg.level_mode |=> !o_irq_oe_n && o_irq == $past(lvl); endproperty
    a_edge: assert property (p_edge) else $error("edge irq");
    property p_lvl; i_irq_cfg.level_mode && act |=> !o_irq_oe_n && !o_irq; endproperty
    a_lvl: assert property (p_lvl) else $error("level irq");
    property p_off; i_irq_cfg.level_mode && !act |=> o_irq_oe_n; endproperty
    a_off: assert property (p_off) else $error("irq off");
    property p_rxv; i_ss_n [*8] |-> !o_rx_valid; endproperty
    a_rxv: assert property (p_rxv) else $error("rx idle");
endmodule : hpo_props

bind hpo_top hpo_props u_props (.*);

/* verification/hpo_spi_master.sv */
// Serial master model driving the data pins
`timescale 1ns/1ps
module hpo_spi_master (
    input  wire logic i_miso,
    output logic      o_sclk,
    output logic      o_ss_n,
    output logic      o_mosi,
    output logic      o_mosi_en
);
    initial begin
        o_sclk    = 1'h0;
        o_ss_n    = 1'h1;
        o_mosi    = 1'h0;
        o_mosi_en = 1'h1;
    end
    // Clock stands low outside frames; rd releases the shared wire
    task automatic xfer(input logic [7:0] tx, input logic rd, output logic [7:0] rx);
        o_mosi_en = !rd;
        o_ss_n    = 1'h0;
        #250;
        // Uneven halves keep every pin change on the bench's falling edge
        for (int i = 7; i >= 0; i--) begin
            o_mosi = tx[i];
            #60 o_sclk = 1'h1;
            rx[i] = i_miso;
            #65 o_sclk = 1'h0;
        end
        #125 o_ss_n = 1'h1;
        // Shared wire is taken back only after the device has let go
        #250;
        o_mosi_en = 1'h1;
    endtask : xfer
endmodule : hpo_spi_master

/* verification/hpo_top_tb.sv */
// Testbench for the host-side pin output stage
`timescale 1ns/1ps
module hpo_top_tb
    import hpo_pkg::*;
;
    logic         i_clock, i_rst_n, i_sclk, i_ss_n, i_mosi, i_half_duplex, i_tx_load;
    logic         i_irq_pending, o_miso, o_miso_oe_n, o_mosi, o_mosi_oe_n, o_rx_valid;
    logic         o_muxed_status_out, o_irq, o_irq_oe_n, m_mosi, m_en, act;
    logic [7:0]   i_tx_byte, o_rx_byte, seen;
    logic [1:0]   i_status_sel;
    hpo_status_t  i_status;
    hpo_irq_cfg_t i_irq_cfg;
    int           mismatches, check_count;
    // No pull on the shared wire: a released line shows the inverse
    assign i_mosi = !o_mosi_oe_n ? o_mosi : (m_en ? m_mosi : ~o_mosi);
    hpo_top dut (.*);
    hpo_spi_master u_m (
        .i_miso    (i_half_duplex ? i_mosi : (o_miso_oe_n ? ~o_miso : o_miso)),
        .o_sclk    (i_sclk),
        .o_ss_n    (i_ss_n),
        .o_mosi    (m_mosi),
        .o_mosi_en (m_en)
    );
    always #2.5 i_clock = ~i_clock;
    always @(negedge i_clock) if (o_rx_valid === 1'h1)
        seen <= o_rx_byte;
    // ****************
    // Tasks
    // ****************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic run(input logic hd, input logic [7:0] dev, input logic [7:0] mst);
        logic [7:0] rx;
        @(negedge i_clock);
        i_half_duplex = hd;
        i_tx_byte     = dev;
        u_m.xfer(mst, hd, rx);
        chk(rx, dev);
        if (!hd)
            chk(seen, mst);
    endtask : run
    task automatic complete_run();
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    initial begin
        #100000;
        mismatches++;
        complete_run();
    end
    initial begin
        {i_clock, i_rst_n, i_half_duplex, i_tx_load, i_irq_pending} = 5'h2;
        {i_tx_byte, i_status_sel, i_status, i_irq_cfg} = 17'h0;
        repeat (16) @(posedge i_clock);
        @(negedge i_clock) i_rst_n = 1'h1;
        repeat (4) @(negedge i_clock);
        chk(8'(o_miso_oe_n), 8'h1);
        run(1'h0, 8'ha5, 8'h3c);
        run(1'h0, 8'h5a, 8'h81);
        run(1'h1, 8'h96, 8'h00);
        for (int s = 0; s < 8; s++) begin
            @(negedge i_clock);
            i_status_sel = 2'(s);
            i_status = s[2] ? ~(4'h8 >> s[1:0]) : 4'h8 >> s[1:0];
            @(negedge i_clock);
            chk(8'(o_muxed_status_out), 8'(!s[2]));
        end
        for (int c = 0; c < 16; c++) begin
            @(negedge i_clock);
            {i_irq_cfg, i_irq_pending} = 4'(c);
            @(negedge i_clock);
            act = c[3] & c[0];
            chk(8'({o_irq_oe_n, o_irq}), c[2] ? 8'({!act, 1'h0}) : 8'({1'h0, c[1] ^ !act}));
        end
        complete_run();
    end
endmodule : hpo_top_tb
